//--- ioc_pkg.sv
// Constants, offsets, field layouts and codes shared by the I/O configuration command handler.
`default_nettype none
package ioc_pkg;
	// Register byte offsets.
	localparam logic [7:0] ADDR_CMD = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_REPLY = 8'h08;
	localparam logic [7:0] ADDR_FORMAT = 8'h0C;
	localparam logic [7:0] ADDR_INPUTS = 8'h10;
	localparam logic [7:0] ADDR_CHAR = 8'h14;
	localparam logic [7:0] ADDR_TERM = 8'h18;
	// Command word fields.
	localparam int CMD_OP_LSB = 0;
	localparam int CMD_CH_LSB = 8;
	localparam int CMD_ARG_LSB = 16;
	localparam int CMD_STATE_BIT = 24;
	// Reply and status word fields.
	localparam int REPLY_AUX_LSB = 16;
	localparam int REPLY_STATE_BIT = 24;
	localparam int REPLY_UNIFORM_BIT = 25;
	localparam int STATUS_EXP_BIT = 8;
	// Command opcodes.
	localparam logic [3:0] OP_SET_VOUT = 4'h1;
	localparam logic [3:0] OP_GET_VOUT = 4'h2;
	localparam logic [3:0] OP_DIG_IN = 4'h3;
	localparam logic [3:0] OP_GET_DIN = 4'h4;
	localparam logic [3:0] OP_SET_DIN = 4'h5;
	localparam logic [3:0] OP_GET_DOUT = 4'h6;
	localparam logic [3:0] OP_SET_DOUT = 4'h7;
	localparam logic [3:0] OP_DTOA = 4'h8;
	localparam logic [3:0] OP_LIST_VAR = 4'h9;
	localparam logic [3:0] OP_GET_RELAY = 4'hA;
	localparam logic [3:0] OP_SET_RELAY = 4'hB;
	// Result codes.
	localparam logic [1:0] RES_NONE = 2'h0;
	localparam logic [1:0] RES_OK = 2'h1;
	localparam logic [1:0] RES_REJECT = 2'h2;
	localparam logic [1:0] RES_NOT_ENABLED = 2'h3;
	// Limits.
	localparam logic [4:0] VOUT_CH_MAX = 5'h06;
	localparam logic [4:0] RANGE_MAX = 5'h04;
	localparam logic [4:0] DIO_CH_MAX = 5'h10;
	localparam logic [4:0] DIN_IDX_MAX = 5'h0C;
	localparam logic [4:0] DOUT_IDX_MAX = 5'h1F;
	localparam logic [4:0] QTY_COUNT = 5'h06;
	localparam logic [4:0] AOUT_VARS = 5'h16;
	// List classes.
	localparam logic [4:0] CLASS_AOUT = 5'h00;
	localparam logic [4:0] CLASS_LOG = 5'h03;
	// Reset values.
	localparam logic [2:0] RANGE_RST = 3'h0;
	localparam logic [15:0] RELAY_RST = 16'h0000;
	localparam logic FORMAT_RST = 1'b0;
	// Termination bytes and last sequence position.
	localparam logic [7:0] CH_CR = 8'h0D;
	localparam logic [7:0] CH_NL = 8'h0A;
	localparam logic [7:0] CH_S = 8'h73;
	localparam logic [7:0] CH_U = 8'h75;
	localparam logic [7:0] CH_M = 8'h6D;
	localparam logic [7:0] CH_SP = 8'h20;
	localparam logic [3:0] TERM_LAST = 4'h9;

	typedef enum logic {TERM_IDLE, TERM_RUN} ioc_term_e;

	// Analog output and logging variable indices, in list order.
	function automatic logic [5:0] ioc_aout_var(input logic [4:0] pos);
		logic [5:0] v;
		v = 6'h00;
		unique case (pos)
			5'h00: v = 6'h00;
			5'h01: v = 6'h01;
			5'h02: v = 6'h03;
			5'h03: v = 6'h04;
			5'h04: v = 6'h06;
			5'h05: v = 6'h08;
			5'h06: v = 6'h09;
			5'h07: v = 6'h0B;
			5'h08: v = 6'h0C;
			5'h09: v = 6'h0D;
			5'h0A: v = 6'h0F;
			5'h0B: v = 6'h11;
			5'h0C: v = 6'h13;
			5'h0D: v = 6'h1C;
			5'h0E: v = 6'h1D;
			5'h0F: v = 6'h1E;
			5'h10: v = 6'h20;
			5'h11: v = 6'h22;
			5'h12: v = 6'h2D;
			5'h13: v = 6'h32;
			5'h14: v = 6'h34;
			5'h15: v = 6'h35;
			default: v = 6'h00;
		endcase
		return v;
	endfunction
endpackage
`default_nettype wire

//--- ioc_term_if.sv
// Interface between the command handler and its reply terminator generator.
`timescale 1ns/1ns
`default_nettype none
interface ioc_term_if;
	logic char_we;
	logic [7:0] char_data;
	logic start;
	logic fmt;
	logic pop;
	logic [7:0] term_byte;
	logic term_valid;
	logic [15:0] sum;
	modport ctl (output char_we, char_data, start, fmt, pop, input term_byte, term_valid, sum);
	modport gen (input char_we, char_data, start, fmt, pop, output term_byte, term_valid, sum);
endinterface
`default_nettype wire

//--- ioc_term_gen.sv
// Reply terminator generator: byte sum of the reply text and the termination sequence.
`timescale 1ns/1ns
`default_nettype none
module ioc_term_gen
(
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Link to the handler
	ioc_term_if.gen t
);
	import ioc_pkg::*;

	logic [15:0] sum_reg;
	logic [15:0] held_reg;
	logic fmt_reg;
	logic [3:0] pos_reg;
	ioc_term_e state_reg;

	function automatic logic [7:0] hex_char(input logic [3:0] n);
		return (n < 4'hA) ? (8'h30 + {4'h0, n}) : (8'h57 + {4'h0, n});
	endfunction

	// The sum restarts with each new reply so consecutive replies do not accumulate.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			sum_reg <= 16'h0000;
		else if (t.start)
			sum_reg <= 16'h0000;
		else if (t.char_we)
			sum_reg <= sum_reg + {8'h00, t.char_data};
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			state_reg <= TERM_IDLE;
			pos_reg <= 4'h0;
			held_reg <= 16'h0000;
			fmt_reg <= FORMAT_RST;
		end
		else if (t.start)
		begin
			state_reg <= TERM_RUN;
			held_reg <= sum_reg;
			fmt_reg <= t.fmt;
			pos_reg <= t.fmt ? 4'h0 : TERM_LAST;
		end
		else if (t.pop && state_reg == TERM_RUN)
		begin
			if (pos_reg == TERM_LAST)
				state_reg <= TERM_IDLE;
			else
				pos_reg <= pos_reg + 4'h1;
		end
	end

	always_comb
	begin
		unique case (pos_reg)
			4'h0: t.term_byte = CH_NL;
			4'h1: t.term_byte = CH_S;
			4'h2: t.term_byte = CH_U;
			4'h3: t.term_byte = CH_M;
			4'h4: t.term_byte = CH_SP;
			4'h5: t.term_byte = hex_char(held_reg[15:12]);
			4'h6: t.term_byte = hex_char(held_reg[11:8]);
			4'h7: t.term_byte = hex_char(held_reg[7:4]);
			4'h8: t.term_byte = hex_char(held_reg[3:0]);
			default: t.term_byte = CH_CR;
		endcase
	end

	assign t.term_valid = (state_reg == TERM_RUN);
	assign t.sum = sum_reg;
endmodule
`default_nettype wire

//--- ioc_io_cmd.sv
// I/O configuration command handler with an AHB-Lite register slave.
// Functional notes
// - Voltage range set needs channel 1 to 6.
// - Range codes: 1=1V, 2=100mV, 3=10V, 4=5V.
// - Code 0 reportable, never accepted when set.
// - Input query returns 16-bit word, MSB input 16.
// - Input query gives channel, index, state.
// - Input action fires on transition to level.
// - Output query gives channel, index, open/closed.
// - Output assign stores index and state.
// - Converter query returns percent of full scale; the code returns the dac_level input unscaled.
// - Unproduced quantity reads as zero level.
// - Defaults: 1-6 voltage, 7-12 current, six quantities.
// - Listing returns one entry per channel.
// - Variable lists return selectable indices per class.
// - Uniform relays report a single open/closed.
// - Mixed relays report word, bit0 relay 1.
// - Relay set addresses relay 1 to 16.
// - Relay set without number sets all relays.
// - Accepted set commands answer ok.
// - Format 00 ends CR; 01 adds sum digits.
// - Voltage range commands refused without expansion hardware.
//
// Local design decisions: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module ioc_io_cmd
#(
	parameter int NUM_DAC = 12,
	parameter int LEVEL_W = 10
)
(
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Instrument state
	input wire logic expansion_present,
	input wire logic [15:0] din_level,
	input wire logic [NUM_DAC*LEVEL_W-1:0] dac_level,
	input wire logic [ioc_pkg::QTY_COUNT-1:0] qty_avail,
	input wire logic [31:0] var_avail,
	// Configuration outputs
	output logic [17:0] vout_range,
	output logic [15:0] relay_open,
	output logic [15:0] dout_open,
	output logic din_action_valid,
	output logic [3:0] din_action_index
);
	import ioc_pkg::*;

	ioc_term_if tif();

	logic dp_active_reg;
	logic dp_write_reg;
	logic [7:0] dp_addr_reg;
	logic [31:0] rdata_reg;
	logic format_reg;
	logic [1:0] result_reg;
	logic [31:0] reply_reg;
	logic [31:0] last_cmd_reg;
	logic [2:0] range_reg [0:5];
	logic [3:0] din_idx_reg [0:15];
	logic [15:0] din_high_reg;
	logic [4:0] dout_idx_reg [0:15];
	logic [15:0] dout_open_reg;
	logic [15:0] relay_reg;
	logic [15:0] din_prev_reg;
	logic act_valid_reg;
	logic [3:0] act_index_reg;
	logic [LEVEL_W-1:0] level [0:NUM_DAC-1];

	logic addr_take;
	logic cmd_go;
	logic [3:0] op;
	logic [4:0] ch;
	logic [4:0] arg;
	logic st;
	logic [3:0] chi;
	logic [1:0] result_next;
	logic [31:0] reply_next;
	logic [4:0] qty;
	logic act_hit;
	logic [3:0] act_idx;

	function automatic logic in_range(input logic [4:0] v, input logic [4:0] lo, input logic [4:0] hi);
		return (v >= lo) && (v <= hi);
	endfunction

	genvar g;
	generate
		for (g = 0; g < NUM_DAC; g++)
		begin : g_lvl
			assign level[g] = dac_level[g*LEVEL_W +: LEVEL_W];
		end
		for (g = 0; g < 6; g++)
		begin : g_rng
			assign vout_range[g*3 +: 3] = range_reg[g];
		end
	endgenerate

	// The slave never stalls, so every response is zero wait state and OKAY.
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = rdata_reg;
	assign addr_take = hsel && htrans[1] && hready;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			dp_active_reg <= 1'b0;
			dp_write_reg <= 1'b0;
			dp_addr_reg <= 8'h00;
		end
		else if (hready)
		begin
			dp_active_reg <= addr_take;
			dp_write_reg <= hwrite;
			dp_addr_reg <= haddr[7:0];
		end
	end

	// Read data is captured at the address phase so it stands through the data phase.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			rdata_reg <= 32'h00000000;
		else if (addr_take && !hwrite)
		begin
			unique case (haddr[7:0])
				ADDR_CMD: rdata_reg <= last_cmd_reg;
				ADDR_STATUS: rdata_reg <= {23'h000000, expansion_present, 6'h00, result_reg};
				ADDR_REPLY: rdata_reg <= reply_reg;
				ADDR_FORMAT: rdata_reg <= {31'h00000000, format_reg};
				ADDR_INPUTS: rdata_reg <= {16'h0000, din_level};
				ADDR_CHAR: rdata_reg <= {16'h0000, tif.sum};
				ADDR_TERM: rdata_reg <= {23'h000000, tif.term_valid, tif.term_byte};
				default: rdata_reg <= 32'h00000000;
			endcase
		end
	end

	assign tif.pop = addr_take && !hwrite && haddr[7:0] == ADDR_TERM;
	assign tif.char_we = dp_active_reg && dp_write_reg && dp_addr_reg == ADDR_CHAR;
	assign tif.char_data = hwdata[7:0];
	assign tif.start = dp_active_reg && dp_write_reg && dp_addr_reg == ADDR_TERM;
	assign tif.fmt = format_reg;

	ioc_term_gen u_term
	(
		.hclk(hclk),
		.hresetn(hresetn),
		.t(tif.gen)
	);

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			format_reg <= FORMAT_RST;
		else if (dp_active_reg && dp_write_reg && dp_addr_reg == ADDR_FORMAT)
			format_reg <= hwdata[0];
	end

	assign cmd_go = dp_active_reg && dp_write_reg && dp_addr_reg == ADDR_CMD;
	assign op = hwdata[CMD_OP_LSB +: 4];
	assign ch = hwdata[CMD_CH_LSB +: 5];
	assign arg = hwdata[CMD_ARG_LSB +: 5];
	assign st = hwdata[CMD_STATE_BIT];
	assign chi = 4'(ch - 5'h01);
	// Converters repeat the six quantities, voltage group first, current group second.
	assign qty = (ch > QTY_COUNT) ? 5'(ch - QTY_COUNT - 5'h01) : 5'(ch - 5'h01);

	always_comb
	begin
		result_next = RES_REJECT;
		reply_next = 32'h00000000;
		unique case (op)
			OP_SET_VOUT, OP_GET_VOUT:
			begin
				if (!expansion_present)
					result_next = RES_NOT_ENABLED;
				else if (in_range(ch, 5'h01, VOUT_CH_MAX))
				begin
					if (op == OP_GET_VOUT)
					begin
						result_next = RES_OK;
						reply_next = {29'h00000000, range_reg[chi[2:0]]};
					end
					else if (in_range(arg, 5'h01, RANGE_MAX))
						result_next = RES_OK;
				end
			end
			OP_DIG_IN:
			begin
				result_next = RES_OK;
				reply_next = {16'h0000, din_level};
			end
			OP_GET_DIN:
			begin
				if (in_range(ch, 5'h01, DIO_CH_MAX))
				begin
					result_next = RES_OK;
					reply_next = {7'h00, din_high_reg[chi], 4'h0, din_idx_reg[chi], 11'h000, ch};
				end
			end
			OP_SET_DIN:
			begin
				if (in_range(ch, 5'h01, DIO_CH_MAX) && in_range(arg, 5'h01, DIN_IDX_MAX))
					result_next = RES_OK;
			end
			OP_GET_DOUT:
			begin
				if (in_range(ch, 5'h01, DIO_CH_MAX))
				begin
					result_next = RES_OK;
					reply_next = {7'h00, dout_open_reg[chi], 3'h0, dout_idx_reg[chi], 11'h000, ch};
				end
			end
			OP_SET_DOUT:
			begin
				if (in_range(ch, 5'h01, DIO_CH_MAX) && in_range(arg, 5'h01, DOUT_IDX_MAX))
					result_next = RES_OK;
			end
			OP_DTOA:
			begin
				if (ch >= 5'h01 && 32'(ch) <= NUM_DAC)
				begin
					result_next = RES_OK;
					reply_next[REPLY_AUX_LSB +: 5] = qty;
					reply_next[REPLY_STATE_BIT] = (ch > QTY_COUNT);
					if (qty_avail[qty[2:0]])
						reply_next[LEVEL_W-1:0] = level[chi];
				end
			end
			OP_LIST_VAR:
			begin
				if (arg == CLASS_AOUT || arg == CLASS_LOG)
				begin
					if (ch < AOUT_VARS && var_avail[ch])
					begin
						result_next = RES_OK;
						reply_next = {26'h0000000, ioc_aout_var(ch)};
					end
				end
				else if (arg < CLASS_LOG && ch < DIN_IDX_MAX && var_avail[ch])
				begin
					result_next = RES_OK;
					reply_next = {27'h0000000, 5'(ch + 5'h01)};
				end
			end
			OP_GET_RELAY:
			begin
				result_next = RES_OK;
				reply_next = {16'h0000, relay_reg};
				reply_next[REPLY_STATE_BIT] = relay_reg[0];
				reply_next[REPLY_UNIFORM_BIT] = (relay_reg == 16'h0000) || (relay_reg == 16'hFFFF);
			end
			OP_SET_RELAY:
			begin
				if (ch <= DIO_CH_MAX)
					result_next = RES_OK;
			end
			default: result_next = RES_REJECT;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			result_reg <= RES_NONE;
			reply_reg <= 32'h00000000;
			last_cmd_reg <= 32'h00000000;
		end
		else if (cmd_go)
		begin
			result_reg <= result_next;
			reply_reg <= reply_next;
			last_cmd_reg <= hwdata;
		end
	end

	// Every configuration store below (ranges, inputs, outputs, relays) commits only on an accepted command.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			for (int i = 0; i < 6; i++)
				range_reg[i] <= RANGE_RST;
		end
		else if (cmd_go && op == OP_SET_VOUT && result_next == RES_OK)
			range_reg[chi[2:0]] <= arg[2:0];
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			for (int i = 0; i < 16; i++)
				din_idx_reg[i] <= 4'h0;
			din_high_reg <= 16'h0000;
		end
		else if (cmd_go && op == OP_SET_DIN && result_next == RES_OK)
		begin
			din_idx_reg[chi] <= arg[3:0];
			din_high_reg[chi] <= st;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			for (int i = 0; i < 16; i++)
				dout_idx_reg[i] <= 5'h00;
			dout_open_reg <= 16'h0000;
		end
		else if (cmd_go && op == OP_SET_DOUT && result_next == RES_OK)
		begin
			dout_idx_reg[chi] <= arg;
			dout_open_reg[chi] <= st;
		end
	end
	assign dout_open = dout_open_reg;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			relay_reg <= RELAY_RST;
		else if (cmd_go && op == OP_SET_RELAY && result_next == RES_OK)
		begin
			if (ch == 5'h00)
				relay_reg <= {16{st}};
			else
				relay_reg[chi] <= st;
		end
	end
	assign relay_open = relay_reg;

	// With several inputs firing together the lowest channel wins; the others are dropped.
	always_comb
	begin
		act_hit = 1'b0;
		act_idx = 4'h0;
		for (int i = 15; i >= 0; i--)
		begin
			if (din_level[i] != din_prev_reg[i] && din_level[i] == din_high_reg[i] && din_idx_reg[i] != 4'h0)
			begin
				act_hit = 1'b1;
				act_idx = din_idx_reg[i];
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			din_prev_reg <= 16'h0000;
			act_valid_reg <= 1'b0;
			act_index_reg <= 4'h0;
		end
		else
		begin
			din_prev_reg <= din_level;
			act_valid_reg <= act_hit;
			act_index_reg <= act_idx;
		end
	end
	assign din_action_valid = act_valid_reg;
	assign din_action_index = act_index_reg;

	logic unused_ok;
	assign unused_ok = &{1'b0, hsize, haddr[31:8], hwdata[31:25]};
endmodule
`default_nettype wire

//--- ioc_io_cmd_assertions.sv
// Concurrent checks on the ports of the I/O configuration command handler.
`timescale 1ns/1ns
`default_nettype none
module ioc_io_cmd_checker
#(
	parameter int NUM_DAC = 12,
	parameter int LEVEL_W = 10
)
(
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Bus
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	// Instrument side
	input wire logic [15:0] din_level,
	input wire logic [17:0] vout_range,
	input wire logic [15:0] relay_open,
	input wire logic [15:0] dout_open,
	input wire logic din_action_valid,
	input wire logic [3:0] din_action_index
);
	import ioc_pkg::*;
	logic dp_cmd;
	logic bad_rng;
	logic [4:0] ch;
	logic [3:0] op;
	assign ch = hwdata[12:8];
	assign op = hwdata[3:0];
	// A command only takes effect at the end of its data phase, so the phase is tracked here.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			dp_cmd <= 1'b0;
		else if (hready)
			dp_cmd <= hsel && htrans[1] && hwrite && haddr[7:0] == ADDR_CMD;
	end
	always_comb
	begin
		bad_rng = 1'b0;
		for (int c = 0; c < 6; c++)
			if (vout_range[c*3+:3] > 3'h4)
				bad_rng = 1'b1;
	end
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	bus_okay_a: assert property (hreadyout && !hresp)
		else $error("bus answer not zero-wait okay");
	range_legal_a: assert property (!bad_rng)
		else $error("voltage range field holds an unknown code");
	range_cause_a: assert property (!$stable(vout_range) |-> $past(dp_cmd) && $past(op) == OP_SET_VOUT
		&& $past(ch) inside {[5'h01:VOUT_CH_MAX]} && $past(hwdata[20:16]) inside {[5'h01:RANGE_MAX]})
		else $error("voltage range changed without a legal set");
	relay_cause_a: assert property (!$stable(relay_open) |-> $past(dp_cmd) && $past(op) == OP_SET_RELAY)
		else $error("relay logic changed without a relay set");
	dout_cause_a: assert property (!$stable(dout_open) |-> $past(dp_cmd) && $past(op) == OP_SET_DOUT)
		else $error("output state changed without an output set");
	relay_all_a: assert property (dp_cmd && op == OP_SET_RELAY && ch == 5'h00
		|=> relay_open == {16{$past(hwdata[24])}})
		else $error("relay set for all relays not applied");
	relay_one_a: assert property (dp_cmd && op == OP_SET_RELAY && ch inside {[5'h01:5'h10]}
		|=> relay_open[$past(ch) - 5'h01] == $past(hwdata[24]))
		else $error("single relay set not applied");
	din_cause_a: assert property (din_action_valid |-> $past(din_level) != $past(din_level, 2))
		else $error("input action without an input transition");
	din_index_a: assert property (din_action_valid |-> din_action_index inside {[4'h1:4'hC]})
		else $error("input action index out of range");
	cover property (dp_cmd && op == OP_SET_RELAY);
	cover property (din_action_valid);
	cover property (!$stable(vout_range));
endmodule
bind ioc_io_cmd ioc_io_cmd_checker #(.NUM_DAC(NUM_DAC), .LEVEL_W(LEVEL_W)) u_chk
(
	.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
	.din_level(din_level), .vout_range(vout_range), .relay_open(relay_open), .dout_open(dout_open),
	.din_action_valid(din_action_valid), .din_action_index(din_action_index)
);
`default_nettype wire

//--- ioc_ahb_host.sv
// AHB-Lite single-transfer master standing in for the remote host.
`timescale 1ns/1ns
`default_nettype none
module ioc_ahb_host
(
	// Clock
	input wire logic hclk,
	// Master request
	output logic hsel,
	output logic [31:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [2:0] hsize,
	output logic [31:0] hwdata,
	// Slave answer
	input wire logic hready,
	input wire logic [31:0] hrdata
);
	initial
	begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
	end
	task aph(input logic [7:0] a, input logic w);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		aph(a, 1'b1);
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		// Stale write data is inverted so a slave that samples late cannot pass by luck.
		hwdata <= ~d;
	endtask
	task rd(input logic [7:0] a, output logic [31:0] r);
		aph(a, 1'b0);
		do @(posedge hclk); while (hready !== 1'b1);
		r = hrdata;
	endtask
endmodule
`default_nettype wire

//--- ioc_io_cmd_bench.sv
// Self-checking bench for the I/O configuration command handler.
`timescale 1ns/1ns
`default_nettype none
module ioc_io_cmd_bench;
	import ioc_pkg::*;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel, hwrite, hreadyout, hresp, din_action_valid;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic expansion_present = 1'b1;
	logic [15:0] din_level = 16'h0000;
	logic [119:0] dac_level = 120'h0;
	logic [5:0] qty_avail = 6'h05;
	logic [31:0] var_avail = 32'hFFFFFFFF;
	logic [17:0] vout_range;
	logic [15:0] relay_open, dout_open;
	logic [3:0] din_action_index;
	logic [31:0] bad [7];
	logic [7:0] tb [10] = '{8'h0A, 8'h73, 8'h75, 8'h6D, 8'h20, 8'h30, 8'h30, 8'h64, 8'h61, 8'h0D};
	int n_fail = 0;
	int compares = 0;
	always #20 hclk = ~hclk;
	ioc_ahb_host u_host (.hclk(hclk), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata));
	ioc_io_cmd u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .expansion_present(expansion_present), .din_level(din_level),
		.dac_level(dac_level), .qty_avail(qty_avail), .var_avail(var_avail), .vout_range(vout_range),
		.relay_open(relay_open), .dout_open(dout_open), .din_action_valid(din_action_valid),
		.din_action_index(din_action_index));
	task tally_and_finish;
		$display("compares %0d mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] seen, exp);
		compares++;
		if (seen !== exp)
		begin
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
			n_fail++;
		end
	endtask
	function automatic logic [31:0] cw(input logic [3:0] op, input logic [4:0] ch, arg, input logic st);
		return {7'h00, st, 3'h0, arg, 3'h0, ch, 4'h0, op};
	endfunction
	task rchk(input logic [7:0] a, input string nm, input logic [31:0] m, exp);
		logic [31:0] r;
		u_host.rd(a, r);
		chk(nm, r & m, exp);
	endtask
	task cmd(input logic [31:0] w, input logic [1:0] res);
		u_host.wr(ADDR_CMD, w);
		rchk(ADDR_STATUS, "status", 32'h3, {30'h0, res});
	endtask
	task ask(input logic [31:0] w, input logic [31:0] m, exp);
		cmd(w, RES_OK);
		rchk(ADDR_REPLY, "reply", m, exp);
	endtask
	initial
	begin
		repeat (5000) @(posedge hclk);
		n_fail++;
		tally_and_finish();
	end
	initial
	begin
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		chk("reset ranges", {14'h0, vout_range}, 32'h0);
		rchk(ADDR_FORMAT, "format", 32'h1, 32'h0);
		for (int c = 1; c <= 6; c++)
			cmd(cw(OP_SET_VOUT, 5'(c), 5'((c - 1) % 4 + 1), 1'b0), RES_OK);
		chk("ranges", {14'h0, vout_range}, 32'h118D1);
		ask(cw(OP_GET_VOUT, 5'h03, 5'h00, 1'b0), 32'h7, 32'h3);
		bad = '{cw(OP_SET_VOUT, 5'h00, 5'h03, 1'b0), cw(OP_SET_VOUT, 5'h07, 5'h03, 1'b0),
			cw(OP_SET_VOUT, 5'h02, 5'h00, 1'b0), cw(OP_SET_VOUT, 5'h02, 5'h05, 1'b0),
			cw(OP_SET_DIN, 5'h01, 5'h0D, 1'b1), cw(OP_SET_RELAY, 5'h11, 5'h00, 1'b1),
			cw(OP_SET_DOUT, 5'h11, 5'h03, 1'b1)};
		foreach (bad[i])
			cmd(bad[i], RES_REJECT);
		chk("ranges kept", {14'h0, vout_range}, 32'h118D1);
		chk("relays kept", {relay_open, dout_open}, 32'h0);
		expansion_present <= 1'b0;
		cmd(cw(OP_SET_VOUT, 5'h01, 5'h03, 1'b0), RES_NOT_ENABLED);
		rchk(ADDR_STATUS, "expansion flag", 32'h100, 32'h0);
		chk("ranges idle", {14'h0, vout_range}, 32'h118D1);
		expansion_present <= 1'b1;
		cmd(cw(OP_SET_DIN, 5'h01, 5'h03, 1'b1), RES_OK);
		rchk(ADDR_STATUS, "expansion flag", 32'h100, 32'h100);
		ask(cw(OP_GET_DIN, 5'h01, 5'h00, 1'b0), 32'h011F001F, 32'h01030001);
		din_level <= 16'h8001;
		// The pulse is looked at on the falling edge, where it has settled, and must last one cycle only.
		for (int i = 0; i < 10 && din_action_valid !== 1'b1; i++)
			@(negedge hclk);
		chk("input action", {din_action_valid, din_action_index}, 32'h13);
		@(negedge hclk);
		chk("input action end", {31'h0, din_action_valid}, 32'h0);
		@(posedge hclk);
		ask(cw(OP_DIG_IN, 5'h00, 5'h00, 1'b0), 32'hFFFF, 32'h8001);
		rchk(ADDR_INPUTS, "inputs", 32'hFFFF, 32'h8001);
		cmd(cw(OP_SET_DOUT, 5'h04, 5'h0B, 1'b1), RES_OK);
		chk("outputs", {16'h0, dout_open}, 32'h8);
		rchk(ADDR_CMD, "echo", 32'hFFFFFFFF, cw(OP_SET_DOUT, 5'h04, 5'h0B, 1'b1));
		ask(cw(OP_GET_DOUT, 5'h04, 5'h00, 1'b0), 32'h011F001F, 32'h010B0004);
		dac_level[9:0] <= 10'h3D1;
		dac_level[89:80] <= 10'h155;
		dac_level[99:90] <= 10'h2AA;
		ask(cw(OP_DTOA, 5'h01, 5'h00, 1'b0), 32'h011F03FF, 32'h000003D1);
		ask(cw(OP_DTOA, 5'h09, 5'h00, 1'b0), 32'h011F03FF, 32'h01020155);
		ask(cw(OP_DTOA, 5'h0A, 5'h00, 1'b0), 32'h011F03FF, 32'h01030000);
		ask(cw(OP_LIST_VAR, 5'h02, CLASS_AOUT, 1'b0), 32'h3F, 32'h03);
		ask(cw(OP_LIST_VAR, 5'h0D, CLASS_LOG, 1'b0), 32'h3F, 32'h1C);
		ask(cw(OP_LIST_VAR, 5'h00, 5'h02, 1'b0), 32'h3F, 32'h01);
		cmd(cw(OP_LIST_VAR, 5'h16, CLASS_AOUT, 1'b0), RES_REJECT);
		var_avail <= 32'hFFFFFFFB;
		cmd(cw(OP_LIST_VAR, 5'h02, CLASS_AOUT, 1'b0), RES_REJECT);
		var_avail <= 32'hFFFFFFFF;
		cmd(cw(OP_SET_RELAY, 5'h00, 5'h00, 1'b1), RES_OK);
		ask(cw(OP_GET_RELAY, 5'h00, 5'h00, 1'b0), 32'h0300FFFF, 32'h0300FFFF);
		cmd(cw(OP_SET_RELAY, 5'h01, 5'h00, 1'b0), RES_OK);
		ask(cw(OP_GET_RELAY, 5'h00, 5'h00, 1'b0), 32'h0300FFFF, 32'h0000FFFE);
		u_host.wr(ADDR_FORMAT, 32'h1);
		u_host.wr(ADDR_CHAR, 32'h6F);
		u_host.wr(ADDR_CHAR, 32'h6B);
		rchk(ADDR_CHAR, "sum", 32'hFFFF, 32'hDA);
		u_host.wr(ADDR_TERM, 32'h0);
		foreach (tb[i])
			rchk(ADDR_TERM, "term", 32'h1FF, {23'h0, 1'b1, tb[i]});
		rchk(ADDR_TERM, "term end", 32'h100, 32'h0);
		u_host.wr(ADDR_FORMAT, 32'h0);
		u_host.wr(ADDR_TERM, 32'h0);
		rchk(ADDR_TERM, "cr", 32'h1FF, 32'h10D);
		rchk(ADDR_TERM, "cr end", 32'h100, 32'h0);
		rchk(8'h1C, "unmapped", 32'hFFFFFFFF, 32'h0);
		tally_and_finish();
	end
endmodule
`default_nettype wire
